// >>> shared/pmic_seq_params.svh
// offsets, field positions, reset values and timing counts
`ifndef PMIC_SEQ_PARAMS_SVH
`define PMIC_SEQ_PARAMS_SVH
`define SYS_CTRL_A_OFS  9'h00e
`define SEQ_SLOT_OFS    9'h094
`define DVFS_SET_OFS    9'h0d7
`define BOOST_SET_OFS   9'h0d8
`define SCRATCH_OFS     9'h122
`define RTC_COUNT_OFS   9'h050
`define RTC_ALARM_OFS   9'h051
`define ALARM_CTRL_OFS  9'h052
`define WARM_FLAG_OFS   9'h053
`define SD1_CTRL_OFS    9'h054
`define WAKE_EN_OFS     9'h055
`define RUN_REQ_BIT     0
`define ALARM_ARM_BIT   0
`define ALARM_FIRED_BIT 1
`define SYS_CTRL_A_RST  8'h03
`define SCRATCH_RST     8'h00
`define WARM_FLAG_RST   1'b0
`define RETAIN_SLOT_VAL 8'h99
`define RUN_CLEAR_VAL   8'h02
`define WARM_MARK_VAL   8'h01
`define DVFS_STEP_MV    10
`define CLK_MHZ         10
`define SLOT_TIME_US    100
`define SLOT_CYCLES     (`SLOT_TIME_US * `CLK_MHZ)
`endif

// >>> shared/pmic_seq_pkg.sv
// types shared by both ends of the power manager link
package pmic_seq_pkg;
    typedef logic [8:0] reg_addr_t;
    typedef logic [7:0] reg_data_t;
    typedef enum logic [2:0] {
        ST_OFF, ST_UP, ST_ACTIVE, ST_DOWN, ST_RETAIN, ST_EXIT
    } seq_state_e;
    typedef enum logic [3:0] {
        H_BOOT, H_IDLE, H_SLOT, H_MARK, H_RTC_RD, H_ALARM, H_ARM,
        H_CLR, H_DDR, H_RUN, H_SLEEP
    } host_state_e;
endpackage

// >>> shared/pmic_link_if.sv
// pins and register channel between power manager and soc
`timescale 1ns/1ps
interface pmic_link_if;
    import pmic_seq_pkg::*;
    logic      retention_request_n;
    logic      soc_reset_n;
    logic      warm_boot_flag;
    logic [2:0] sd_sel;
    logic      boost_sel;
    logic      reg_req;
    logic      reg_we;
    reg_addr_t reg_addr;
    reg_data_t reg_wdata;
    logic      reg_ack;
    reg_data_t reg_rdata;
    modport device (
        input  retention_request_n, sd_sel, boost_sel,
        input  reg_req, reg_we, reg_addr, reg_wdata,
        output soc_reset_n, warm_boot_flag, reg_ack, reg_rdata
    );
    modport host (
        output retention_request_n, sd_sel, boost_sel,
        output reg_req, reg_we, reg_addr, reg_wdata,
        input  soc_reset_n, warm_boot_flag, reg_ack, reg_rdata
    );
endinterface

// >>> design/pmic_device.sv
// power manager: sequencer, retention control and register file
//
// Function
// R01 - supply up starts programmed rail order
// R02 - two outputs enable sub-regulator bucks per slot
// R03 - soc reset held until start-up completes
// R04 - sd select pins: low 1.8v, high 3.3v
// R05 - second sd supply low until host writes
// R06 - dvfs setpoint default, host rewritable, 10mv steps
// R07 - overdrive pin high selects boost setpoint
// R08 - boost setpoint default, host rewritable
// R09 - retention request fall powers down, ddr stays
// R10 - pwm active, ddr bucks pfm in retention
// R11 - exit: ddr back to pwm, then start-up
// R12 - wake: gpio edge, key low, pin rise, alarm
// R13 - wake climbs slots then releases soc reset
// R14 - warm flag low at power-up, lost power resets
// R15 - soc samples warm flag, sets before retention
// R16 - scratch loads zero, kept through retention
// R17 - soc sets alarm then clears events
// R18 - alarm match raises internal wake event
// R19 - soc writes slot setup then marks warm
// R20 - soc self-refresh, then clears run request
// R21 - run request cleared enters retention too
`timescale 1ns/1ps
`include "pmic_seq_params.svh"
module pmic_device #(
    parameter int        NUM_RAILS    = 6,
    parameter int        NUM_SLOTS    = 8,
    parameter int        SUB_SLOT0    = 3,
    parameter int        SUB_SLOT1    = 4,
    parameter logic [5:0] DDR_MASK    = 6'h06,
    parameter int        SLOT_CYCLES  = `SLOT_CYCLES,
    parameter logic [7:0] DVFS_DEFAULT  = 8'h50,
    parameter logic [7:0] BOOST_DEFAULT = 8'h5a,
    parameter int        GPIO_W       = 4
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    pmic_link_if.device               link,
    input  wire logic                 supply_good,
    input  wire logic                 power_key_n,
    input  wire logic                 wake_pin_in,
    input  wire logic [GPIO_W-1:0]    gpio_in,
    input  wire logic                 rtc_tick,
    output logic [NUM_RAILS-1:0]      rail_en,
    output logic [1:0]                sub_buck_en,
    output logic [3:0]                sd_level_high,
    output pmic_seq_pkg::reg_data_t   dvfs_code,
    output logic                      ddr_pfm,
    output pmic_seq_pkg::seq_state_e  seq_state
);
    import pmic_seq_pkg::*;

    localparam int CNT_W = $clog2(SLOT_CYCLES + 1);

    seq_state_e       state_reg;
    logic [3:0]       slot_reg;
    logic [CNT_W-1:0] tick_reg;
    logic             retained_reg;
    reg_data_t        ctrl_a_reg;
    reg_data_t        slot_setup_reg;
    reg_data_t        dvfs_reg;
    reg_data_t        boost_reg;
    reg_data_t        scratch_reg;
    reg_data_t        rtc_reg;
    reg_data_t        alarm_reg;
    logic             arm_reg;
    logic             fired_reg;
    logic             warm_reg;
    logic             sd1_high_reg;
    logic [GPIO_W-1:0] wake_en_reg;
    logic [GPIO_W-1:0] gpio_prev_reg;
    logic             ret_prev_reg;
    logic             key_prev_reg;
    logic             pin_prev_reg;
    logic             ack_reg;
    reg_data_t        rdata_reg;
    logic             slot_done;
    logic             wake_event;
    logic             enter_ret;
    logic             alarm_hit;
    logic             wr;

    function automatic logic hit(input reg_addr_t a, input reg_addr_t o);
        return wr && (a == o);
    endfunction

    assign wr        = link.reg_req && link.reg_we;
    assign slot_done = (tick_reg == CNT_W'(SLOT_CYCLES - 1));
    assign alarm_hit = arm_reg && rtc_tick
                     && (rtc_reg + 8'h01 == alarm_reg); // [R18]
    // any wake source, only acted on while retained
    assign wake_event = (link.retention_request_n && !ret_prev_reg)
                      || (!power_key_n && key_prev_reg)
                      || (wake_pin_in && !pin_prev_reg)
                      || (|((gpio_in ^ gpio_prev_reg) & wake_en_reg))
                      || alarm_hit; // [R12] [R18]
    // pin fall or run bit cleared by the host
    assign enter_ret = (!link.retention_request_n && ret_prev_reg)
                     || !ctrl_a_reg[`RUN_REQ_BIT]; // [R09] [R21]

    // edge history of the wake and request inputs
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ret_prev_reg  <= 1'b1;
            key_prev_reg  <= 1'b1;
            pin_prev_reg  <= 1'b0;
            gpio_prev_reg <= '0;
        end else begin
            ret_prev_reg  <= link.retention_request_n;
            key_prev_reg  <= power_key_n;
            pin_prev_reg  <= wake_pin_in;
            gpio_prev_reg <= gpio_in;
        end
    end

    // slot timer, restarts after each slot, held at zero in off, active and retain
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_reg <= '0;
        end else if (state_reg == ST_OFF || state_reg == ST_ACTIVE
                     || state_reg == ST_RETAIN || slot_done) begin
            tick_reg <= '0;
        end else begin
            tick_reg <= tick_reg + CNT_W'(1);
        end
    end

    // power sequencer; supply loss drops straight to off
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg    <= ST_OFF;
            slot_reg     <= '0;
            retained_reg <= 1'b0;
        end else if (!supply_good) begin
            state_reg    <= ST_OFF;
            slot_reg     <= '0;
            retained_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_OFF: begin
                    state_reg <= ST_UP; // [R01]
                end
                ST_UP: begin
                    if (slot_reg == 4'(NUM_SLOTS)) begin
                        state_reg    <= ST_ACTIVE; // [R03] [R13]
                        retained_reg <= 1'b0;
                    end else if (slot_done) begin
                        slot_reg <= slot_reg + 4'h1; // [R01] [R13]
                    end
                end
                ST_ACTIVE: begin
                    if (enter_ret) begin
                        state_reg    <= ST_DOWN; // [R09] [R21]
                        retained_reg <= 1'b1;
                    end
                end
                ST_DOWN: begin
                    if (slot_reg == 4'h0) begin
                        state_reg <= ST_RETAIN;
                    end else if (slot_done) begin
                        slot_reg <= slot_reg - 4'h1;
                    end
                end
                ST_RETAIN: begin
                    if (wake_event) begin
                        state_reg <= ST_EXIT; // [R11] [R12]
                    end
                end
                ST_EXIT: begin
                    // one slot in pwm before rails climb again
                    if (slot_done) begin
                        state_reg <= ST_UP; // [R11]
                    end
                end
                default: begin
                    state_reg <= ST_OFF;
                end
            endcase
        end
    end

    // rail enables follow the slot; ddr rails held while retained
    always_comb begin
        for (int i = 0; i < NUM_RAILS; i++) begin
            rail_en[i] = (slot_reg > 4'(i))
                       || (retained_reg && DDR_MASK[i]); // [R01] [R09]
        end
    end
    assign sub_buck_en[0] = slot_reg > 4'(SUB_SLOT0); // [R02]
    assign sub_buck_en[1] = slot_reg > 4'(SUB_SLOT1); // [R02]
    assign ddr_pfm = (state_reg == ST_RETAIN); // [R10] [R11]
    assign link.soc_reset_n = (state_reg == ST_ACTIVE); // [R03] [R13]
    assign seq_state = state_reg;
    assign link.warm_boot_flag = warm_reg; // [R14]
    // sd0, sd3, sd2 from pins, sd1 from register
    assign sd_level_high = {link.sd_sel[2], sd1_high_reg,
                            link.sd_sel[1:0]}; // [R04] [R05]

    // dvfs output; boost pin overrides the normal setpoint
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            dvfs_code <= '0;
        end else begin
            dvfs_code <= link.boost_sel ? boost_reg : dvfs_reg; // [R07]
        end
    end

    // host-written configuration; only lost with all power
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_setup_reg <= '0;
            dvfs_reg       <= DVFS_DEFAULT;   // [R06]
            boost_reg      <= BOOST_DEFAULT;  // [R08]
            scratch_reg    <= `SCRATCH_RST;   // [R16]
            warm_reg       <= `WARM_FLAG_RST; // [R14]
            sd1_high_reg   <= 1'b0;           // [R05]
            wake_en_reg    <= '0;
            alarm_reg      <= '0;
        end else begin
            if (hit(link.reg_addr, `SEQ_SLOT_OFS))
                slot_setup_reg <= link.reg_wdata;
            if (hit(link.reg_addr, `DVFS_SET_OFS))
                dvfs_reg <= link.reg_wdata; // [R06]
            if (hit(link.reg_addr, `BOOST_SET_OFS))
                boost_reg <= link.reg_wdata; // [R08]
            if (hit(link.reg_addr, `SCRATCH_OFS))
                scratch_reg <= link.reg_wdata; // [R16]
            if (hit(link.reg_addr, `WARM_FLAG_OFS))
                warm_reg <= link.reg_wdata[0];
            if (hit(link.reg_addr, `SD1_CTRL_OFS))
                sd1_high_reg <= link.reg_wdata[0]; // [R05]
            if (hit(link.reg_addr, `WAKE_EN_OFS))
                wake_en_reg <= link.reg_wdata[GPIO_W-1:0];
            if (hit(link.reg_addr, `RTC_ALARM_OFS))
                alarm_reg <= link.reg_wdata;
        end
    end

    // run bit: host clears it, a wake sets it again
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_a_reg <= `SYS_CTRL_A_RST;
        end else begin
            if (hit(link.reg_addr, `SYS_CTRL_A_OFS))
                ctrl_a_reg <= link.reg_wdata; // [R21]
            if (state_reg == ST_RETAIN && wake_event)
                ctrl_a_reg[`RUN_REQ_BIT] <= 1'b1; // [R11]
        end
    end

    // rtc counter and alarm; a new firing beats a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rtc_reg   <= '0;
            arm_reg   <= 1'b0;
            fired_reg <= 1'b0;
        end else begin
            if (hit(link.reg_addr, `RTC_COUNT_OFS))
                rtc_reg <= link.reg_wdata;
            else if (rtc_tick)
                rtc_reg <= rtc_reg + 8'h01;
            if (hit(link.reg_addr, `ALARM_CTRL_OFS)) begin
                arm_reg <= link.reg_wdata[`ALARM_ARM_BIT];
                if (link.reg_wdata[`ALARM_FIRED_BIT])
                    fired_reg <= 1'b0;
            end
            if (alarm_hit) begin
                fired_reg <= 1'b1; // [R18]
                arm_reg   <= 1'b0;
            end
        end
    end

    // register read path, answered one cycle after the request
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= '0;
        end else begin
            ack_reg <= link.reg_req;
            case (link.reg_addr)
                `SYS_CTRL_A_OFS: rdata_reg <= ctrl_a_reg;
                `SEQ_SLOT_OFS:   rdata_reg <= slot_setup_reg;
                `DVFS_SET_OFS:   rdata_reg <= dvfs_reg;
                `BOOST_SET_OFS:  rdata_reg <= boost_reg;
                `SCRATCH_OFS:    rdata_reg <= scratch_reg;
                `RTC_COUNT_OFS:  rdata_reg <= rtc_reg;
                `RTC_ALARM_OFS:  rdata_reg <= alarm_reg;
                `ALARM_CTRL_OFS: rdata_reg <= {6'h00, fired_reg, arm_reg};
                `WARM_FLAG_OFS:  rdata_reg <= {7'h00, warm_reg};
                `SD1_CTRL_OFS:   rdata_reg <= {7'h00, sd1_high_reg};
                `WAKE_EN_OFS:    rdata_reg <= 8'(wake_en_reg);
                default:         rdata_reg <= 8'h00;
            endcase
        end
    end
    assign link.reg_ack   = ack_reg;
    assign link.reg_rdata = rdata_reg;
endmodule

// >>> design/soc_host.sv
// soc side: boot sampling, pin selects and retention entry steps
`timescale 1ns/1ps
`include "pmic_seq_params.svh"
module soc_host (
    input  wire logic                  clk,
    input  wire logic                  rst_n,
    pmic_link_if.host                  link,
    input  wire logic [2:0]            sd_sel_in,
    input  wire logic                  boost_in,
    input  wire logic                  sleep_req,
    input  wire pmic_seq_pkg::reg_data_t sleep_ticks,
    input  wire logic                  ddr_sr_ack,
    output logic                       ddr_sr_req,
    output logic                       warm_boot_seen,
    output logic                       busy
);
    import pmic_seq_pkg::*;

    host_state_e state_reg;
    logic        wait_reg;
    logic        req_reg;
    logic        we_reg;
    reg_addr_t   addr_reg;
    reg_data_t   wdata_reg;
    reg_data_t   rtc_rd_reg;
    reg_data_t   ticks_reg;
    logic        rst_prev_reg;
    logic        sel_boost_reg;
    logic [2:0]  sd_reg;

    // one register access per step: {we, addr, data}
    function automatic logic [17:0] step_cmd(input host_state_e s,
                                             input reg_data_t sum);
        case (s)
            H_SLOT:   return {1'b1, `SEQ_SLOT_OFS, `RETAIN_SLOT_VAL};
            H_MARK:   return {1'b1, `WARM_FLAG_OFS, `WARM_MARK_VAL}; // [R15]
            H_RTC_RD: return {1'b0, `RTC_COUNT_OFS, 8'h00};
            H_ALARM:  return {1'b1, `RTC_ALARM_OFS, sum};
            H_ARM:    return {1'b1, `ALARM_CTRL_OFS, 8'h01};
            H_CLR:    return {1'b1, `ALARM_CTRL_OFS, 8'h03};
            H_RUN:    return {1'b1, `SYS_CTRL_A_OFS, `RUN_CLEAR_VAL};
            default:  return {1'b1, `WARM_FLAG_OFS, 8'h01};
        endcase
    endfunction

    // sd and boost pins to the device come from flops; retention request tied high
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sd_reg        <= '0;
            sel_boost_reg <= 1'b0;
        end else begin
            sd_reg        <= sd_sel_in;       // [R04]
            sel_boost_reg <= boost_in;        // [R07]
        end
    end
    assign link.sd_sel    = sd_reg;
    assign link.boost_sel = sel_boost_reg;
    assign link.retention_request_n = 1'b1;

    // warm flag caught when the soc leaves reset
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_prev_reg   <= 1'b0;
            warm_boot_seen <= 1'b0;
        end else begin
            rst_prev_reg <= link.soc_reset_n;
            if (link.soc_reset_n && !rst_prev_reg)
                warm_boot_seen <= link.warm_boot_flag; // [R15]
        end
    end

    // entry sequence; each register step waits for the device answer
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg  <= H_BOOT;
            wait_reg   <= 1'b0;
            req_reg    <= 1'b0;
            we_reg     <= 1'b0;
            addr_reg   <= '0;
            wdata_reg  <= '0;
            rtc_rd_reg <= '0;
            ticks_reg  <= '0;
            ddr_sr_req <= 1'b0;
        end else begin
            req_reg <= 1'b0;
            case (state_reg)
                H_BOOT: begin
                    ddr_sr_req <= 1'b0;
                    if (link.soc_reset_n)
                        state_reg <= H_IDLE;
                end
                H_IDLE: begin
                    if (sleep_req) begin
                        ticks_reg <= sleep_ticks;
                        state_reg <= H_SLOT;
                    end
                end
                H_DDR: begin
                    ddr_sr_req <= 1'b1;
                    if (ddr_sr_ack)
                        state_reg <= H_RUN; // [R20]
                end
                H_SLEEP: begin
                    if (!link.soc_reset_n)
                        state_reg <= H_BOOT;
                end
                H_SLOT, H_MARK, H_RTC_RD, H_ALARM, H_ARM, H_CLR,
                H_RUN: begin
                    if (!wait_reg) begin
                        {we_reg, addr_reg, wdata_reg} <=
                            step_cmd(state_reg, rtc_rd_reg + ticks_reg);
                        req_reg  <= 1'b1;
                        wait_reg <= 1'b1;
                    end else if (link.reg_ack) begin
                        wait_reg <= 1'b0;
                        case (state_reg)
                            H_SLOT: state_reg <= H_MARK; // [R19]
                            H_MARK: state_reg <= (ticks_reg == 8'h00)
                                                 ? H_CLR : H_RTC_RD;
                            H_RTC_RD: begin
                                rtc_rd_reg <= link.reg_rdata; // [R17]
                                state_reg  <= H_ALARM;
                            end
                            H_ALARM: state_reg <= H_ARM;   // [R17]
                            H_ARM:   state_reg <= H_CLR;
                            H_CLR:   state_reg <= H_DDR;   // [R17]
                            default: state_reg <= H_SLEEP; // [R20]
                        endcase
                    end
                end
                default: state_reg <= H_BOOT;
            endcase
        end
    end
    assign link.reg_req   = req_reg;
    assign link.reg_we    = we_reg;
    assign link.reg_addr  = addr_reg;
    assign link.reg_wdata = wdata_reg;
    assign busy = (state_reg != H_IDLE);
endmodule

// >>> bench/pmic_link_properties.sv
// concurrent checks on the link between power manager and soc
`timescale 1ns/1ps
`include "pmic_seq_params.svh"
module pmic_link_properties (
    input wire logic                    clk,
    input wire logic                    rst_n,
    input wire logic                    retention_request_n,
    input wire logic                    soc_reset_n,
    input wire logic                    warm_boot_flag,
    input wire logic [2:0]              sd_sel,
    input wire logic                    boost_sel,
    input wire logic                    reg_req,
    input wire logic                    reg_we,
    input wire pmic_seq_pkg::reg_addr_t reg_addr,
    input wire pmic_seq_pkg::reg_data_t reg_wdata,
    input wire logic                    reg_ack,
    input wire pmic_seq_pkg::reg_data_t reg_rdata
);
    import pmic_seq_pkg::*;
    reg_data_t scratch_reg;
    logic      slot_set_reg;
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    // shadow of the scratch byte; only reset clears it, retention does not
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scratch_reg <= `SCRATCH_RST;
        end else if (reg_req && reg_we && reg_addr == `SCRATCH_OFS) begin
            scratch_reg <= reg_wdata;
        end
    end

    // remembers that the slot setup write has gone out
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            slot_set_reg <= 1'b0;
        end else if (reg_req && reg_we && reg_addr == `SEQ_SLOT_OFS
                     && reg_wdata == `RETAIN_SLOT_VAL) begin
            slot_set_reg <= 1'b1;
        end
    end

    sequence run_clear_s;
        reg_req && reg_we && reg_addr == `SYS_CTRL_A_OFS
            && reg_wdata == `RUN_CLEAR_VAL;
    endsequence
    sequence scratch_rd_s;
        reg_req && !reg_we && reg_addr == `SCRATCH_OFS;
    endsequence

    ack_follows_req_a: assert property (reg_req |=> reg_ack)
        else $error("register request not acknowledged");
    ack_has_cause_a: assert property (reg_ack |-> $past(reg_req))
        else $error("acknowledge without request");
    host_one_pulse_a: assert property (reg_req |=> !reg_req)
        else $error("host request longer than one cycle");
    boot_reset_hold_a: assert property (
        $rose(rst_n) |-> !soc_reset_n [*8])
        else $error("soc reset released too early");
    cold_flag_a: assert property ($rose(rst_n) |-> !warm_boot_flag)
        else $error("warm flag not low after power-up");
    scratch_value_a: assert property (
        scratch_rd_s |=> reg_rdata == scratch_reg)
        else $error("scratch read data wrong");
    entry_order_a: assert property (run_clear_s |-> slot_set_reg)
        else $error("run request cleared before slot setup");
    run_clear_drop_a: assert property (
        run_clear_s ##0 soc_reset_n |-> ##[1:2] !soc_reset_n)
        else $error("run clear did not start power-down");
endmodule

// >>> bench/pmic_sequencer_retention_ctrl_tb_top.sv
// self-checking bench joining power manager and soc ends
`timescale 1ns/1ps
module pmic_sequencer_retention_ctrl_tb_top;
    import pmic_seq_pkg::*;
    logic       clk, rst_n, supply_good, power_key_n, wake_pin_in, rtc_tick;
    logic       boost_in, sleep_req, ddr_sr_ack, ddr_sr_req, seen, busy;
    logic       ddr_pfm;
    logic [3:0] gpio_in, sd_level_high;
    logic [5:0] rail_en;
    logic [2:0] sd_sel_in;
    logic [1:0] sub_buck_en;
    reg_data_t  dvfs_code, sleep_ticks;
    seq_state_e seq_state;
    int         n_errors, n_tests, cycles;
    integer     seed;
    pmic_link_if link ();

    pmic_device #(.SLOT_CYCLES(4)) u_pmic_device (
        .clk(clk), .rst_n(rst_n), .link(link), .supply_good(supply_good),
        .power_key_n(power_key_n), .wake_pin_in(wake_pin_in),
        .gpio_in(gpio_in), .rtc_tick(rtc_tick), .rail_en(rail_en),
        .sub_buck_en(sub_buck_en), .sd_level_high(sd_level_high),
        .dvfs_code(dvfs_code), .ddr_pfm(ddr_pfm), .seq_state(seq_state));
    soc_host u_soc_host (
        .clk(clk), .rst_n(rst_n), .link(link), .sd_sel_in(sd_sel_in),
        .boost_in(boost_in), .sleep_req(sleep_req),
        .sleep_ticks(sleep_ticks), .ddr_sr_ack(ddr_sr_ack),
        .ddr_sr_req(ddr_sr_req), .warm_boot_seen(seen), .busy(busy));
    pmic_link_properties u_pmic_link_properties (
        .clk(clk), .rst_n(rst_n),
        .retention_request_n(link.retention_request_n),
        .soc_reset_n(link.soc_reset_n), .warm_boot_flag(link.warm_boot_flag),
        .sd_sel(link.sd_sel), .boost_sel(link.boost_sel),
        .reg_req(link.reg_req), .reg_we(link.reg_we),
        .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
        .reg_ack(link.reg_ack), .reg_rdata(link.reg_rdata));

    // 10 mhz clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // memory answers self-refresh one cycle after the request
    always @(posedge clk) ddr_sr_ack <= ddr_sr_req;

    // slow tick so the alarm lands well after retention is reached
    initial forever begin
        rtc_tick = 1'b0;
        repeat (64) @(posedge clk);
        #10 rtc_tick = 1'b1;
        @(posedge clk);
        #10;
    end

    // hang guard
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(string what, logic [31:0] got, logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk);
        #10;
    endtask
    task automatic wait_state(seq_state_e s, int lim);
        for (int i = 0; i < lim && seq_state !== s; i++) step(1);
    endtask
    task automatic wait_idle();
        for (int i = 0; i < 400 && busy !== 1'b0; i++) step(1);
    endtask
    function automatic logic [3:0] sd_expect(logic [2:0] sel);
        return {sel[2], 1'b0, sel[1], sel[0]};
    endfunction
    function automatic reg_data_t dvfs_expect(logic boost);
        return boost ? 8'h5a : 8'h50;
    endfunction

    // wake 0 is the alarm, 1 the power key, 2 the wake pin
    task automatic sleep(reg_data_t ticks, int wake);
        sleep_ticks = ticks;
        sleep_req = 1'b1;
        step(1);
        sleep_req = 1'b0;
        wait_state(ST_RETAIN, 400);
        check("retain", seq_state, ST_RETAIN);
        check("pfm", ddr_pfm, 1'b1);
        check("ddr rails", rail_en, 6'h06);
        if (wake == 1) power_key_n = 1'b0;
        if (wake == 2) wake_pin_in = 1'b1;
        wait_state(ST_EXIT, 1500);
        power_key_n = 1'b1;
        wake_pin_in = 1'b0;
        check("exit", seq_state, ST_EXIT);
        check("exit pwm", ddr_pfm, 1'b0);
        check("exit rails", rail_en, 6'h06);
        wait_state(ST_ACTIVE, 400);
        check("awake", link.soc_reset_n, 1'b1);
        wait_idle();
        check("warm", seen, 1'b1);
    endtask

    task automatic report_and_stop();
        if (n_errors == 0 && n_tests > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        seed = 32'h95ec9c5b;
        rst_n = 1'b0;
        supply_good = 1'b1;
        power_key_n = 1'b1;
        wake_pin_in = 1'b0;
        {gpio_in, sd_sel_in, boost_in} = '0;
        {sleep_req, sleep_ticks} = '0;
        step(2);
        rst_n = 1'b1;
        wait_state(ST_UP, 4);
        check("flag", link.warm_boot_flag, 1'b0);
        // slot order: thermometer rails, sub-bucks tied to their slots
        while (seq_state === ST_UP && cycles < 500) begin
            check("order", rail_en & (rail_en + 6'h01), 6'h00);
            check("sub", sub_buck_en, {rail_en[4], rail_en[3]});
            check("held", link.soc_reset_n, 1'b0);
            step(1);
        end
        check("rails", rail_en, 6'h3f);
        check("released", link.soc_reset_n, 1'b1);
        check("pwm", ddr_pfm, 1'b0);
        wait_idle();
        check("cold", seen, 1'b0);
        for (int i = 0; i < 8; i++) begin
            sd_sel_in = (i == 0) ? 3'h7 : 3'($random(seed));
            boost_in = i[0];
            gpio_in = 4'($random(seed));
            step(3);
            check("sd", sd_level_high, sd_expect(sd_sel_in));
            check("sd1", sd_level_high[2], 1'b0);
            check("dvfs", dvfs_code, dvfs_expect(boost_in));
        end
        boost_in = 1'b0;
        sleep(8'h04 + 8'($random(seed) & 7), 0);
        sleep(8'h00, 1);
        sleep(8'h00, 2);
        supply_good = 1'b0;
        step(2);
        check("off", rail_en, 6'h00);
        supply_good = 1'b1;
        wait_state(ST_ACTIVE, 200);
        check("repower", link.soc_reset_n, 1'b1);
        report_and_stop();
    end
endmodule
